// file: hdl/fcpc_defines.vh
`ifndef FCPC_DEFINES_VH
`define FCPC_DEFINES_VH
// register offsets (word addresses on the plain port)
`define FCPC_ADDR_W 8
`define FCPC_REG_CHCFG 8'h00
`define FCPC_REG_CTRL 8'h01
`define FCPC_REG_SCAN 8'h02
`define FCPC_REG_COUNT0 8'h10
`define FCPC_REG_SETP0 8'h20
`define FCPC_REG_FINAL0 8'h30
`define FCPC_REG_OUTCFG0 8'h40
`define FCPC_REG_OUTSTAT 8'h50
`define FCPC_REG_DIFF0 8'h51
`define FCPC_REG_DIFF1 8'h52
// channel modes
`define FCPC_MODE_EVENT 2'h0
`define FCPC_MODE_DIFF 2'h1
`define FCPC_MODE_REPEAT 2'h2
`define FCPC_MODE_RATE 2'h3
// output trigger kinds
`define FCPC_TRIG_SETP 2'h0
`define FCPC_TRIG_FINAL 2'h1
`define FCPC_TRIG_EDGE 2'h2
`define FCPC_TRIG_DELAY 2'h3
// output config field positions
`define FCPC_OC_CH_LSB 0
`define FCPC_OC_TRIG_LSB 4
`define FCPC_OC_LATCH_BIT 6
`define FCPC_OC_FALL_BIT 7
`define FCPC_OC_DLY_LSB 8
// timing
`define FCPC_CLK_HZ 40000000
`define FCPC_MS_CYCLES (`FCPC_CLK_HZ / 1000)
`define FCPC_RATE_LONG_MS 1000
`define FCPC_RATE_SHORT_MS 100
`define FCPC_DELAY_MAX_MS 16383
`define FCPC_MAX_IN_KHZ 100
`endif

// file: hdl/fcpc_counter.v
`include "fcpc_defines.vh"
// Function
// RULE1 - each of five channels has its own mode field selecting event, differential, repeat or rate.
// RULE2 - event mode counts into 32 bits and its outputs may be latched or timed.
// RULE3 - differential mode pairs channels 0-1 and 2-3 and reports the 32-bit difference, two pairs at most.
// RULE4 - repeat mode uses a 16-bit count that restarts from zero on reaching the setpoint.
// RULE5 - rate mode counts pulses over a repeating window of 1 s or 100 ms and holds the result.
// RULE6 - eight outputs each trigger from a setpoint or a final value in either count direction.
// RULE7 - a setpoint output turns on at the setpoint and latches or gives a one-shot pulse.
// RULE8 - a final-value output turns on at the final value and latches or gives a one-shot pulse.
// RULE9 - an edge output toggles on the rising or falling edge of its count condition.
// RULE10 - a delay output turns on after a programmed delay of up to 16383 ms after the final value.
// RULE11 - count values are copied into a snapshot on every host scan strobe with no request.
// RULE12 - a local-rack host may read live counts at any time, asynchronously to the scan.
// RULE13 - inputs accept pulse trains up to 100 kHz, well within the synchroniser's rate.
// RULE14 - each input is synchronised by two flops and each qualifying edge counts exactly once.
module fcpc_counter #(
	parameter NCH = 5,
	parameter NOUT = 8,
	parameter MS_CYCLES = `FCPC_MS_CYCLES
) (
	// clock and reset
	input wire clk_sys,
	input wire rst_n,
	// pulse inputs and direction
	input wire [NCH-1:0] pulseIn,
	input wire [NCH-1:0] countDown,
	// host scan
	input wire scanStrobe,
	// register port
	input wire [7:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWr,
	input wire regRd,
	output reg [31:0] regRdData,
	// outputs
	output reg [NOUT-1:0] outPin
);
////////////////////////////////////////////////////////////////////////////////
reg [NCH-1:0] syncA, syncB, syncC;
reg [2*NCH-1:0] modeCfg;
reg [NCH-1:0] rateLong;
reg [NCH-1:0] liveSel;
reg [31:0] count [0:NCH-1];
reg [31:0] snap [0:NCH-1];
reg [31:0] rateHold [0:NCH-1];
reg [31:0] setp [0:NCH-1];
reg [31:0] finalVal [0:NCH-1];
reg [31:0] outCfg [0:NOUT-1];
reg [15:0] msDiv;
reg msTick;
reg [9:0] msCnt100;
reg [3:0] tenthCnt;
reg [NOUT-1:0] condPrev;
reg [NOUT-1:0] dlyArmed;
reg condValid;
reg [13:0] dlyCnt [0:NOUT-1];
wire [NCH-1:0] edgeSeen = syncB & ~syncC; // RULE14
// 100 ms and 1 s windows come from one divider so both stay aligned
wire tick100 = msTick && (msCnt100 == 10'd99);
wire tick1s = tick100 && (tenthCnt == 4'd9);
// differences wrap modulo 2^32 and read as two's complement
wire [31:0] diff0 = count[0] - count[1]; // RULE3
wire [31:0] diff1 = count[2] - count[3]; // RULE3
////////////////////////////////////////////////////////////////////////////////
// synchroniser: syncA feeds syncB only
// syncC only delays syncB for the edge detector, nothing else reads syncA
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		syncA <= {NCH{1'b0}};
		syncB <= {NCH{1'b0}};
		syncC <= {NCH{1'b0}};
	end else begin
		syncA <= pulseIn; // RULE14
		syncB <= syncA; // RULE13
		syncC <= syncB;
	end
end
////////////////////////////////////////////////////////////////////////////////
// millisecond base, shared by rate windows and output delays
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		msDiv <= 16'h0000;
		msTick <= 1'b0;
		msCnt100 <= 10'h000;
		tenthCnt <= 4'h0;
	end else begin
		msTick <= (msDiv == MS_CYCLES - 1);
		msDiv <= (msDiv == MS_CYCLES - 1) ? 16'h0000 : msDiv + 16'h0001;
		if (msTick) begin
			msCnt100 <= (msCnt100 == 10'd99) ? 10'h000 : msCnt100 + 10'h001;
			if (msCnt100 == 10'd99)
				tenthCnt <= (tenthCnt == 4'd9) ? 4'h0 : tenthCnt + 4'h1;
		end
	end
end
////////////////////////////////////////////////////////////////////////////////
// channel counters
always @(posedge clk_sys or negedge rst_n) begin : chanRegs
	integer i;
	if (!rst_n) begin
		for (i = 0; i < NCH; i = i + 1) begin
			count[i] <= 32'h00000000;
			rateHold[i] <= 32'h00000000;
			snap[i] <= 32'h00000000;
		end
	end else begin
		for (i = 0; i < NCH; i = i + 1) begin
			case (modeCfg[2*i +: 2]) // RULE1
				`FCPC_MODE_RATE: begin
					// an edge arriving with the window end goes into the held result, the new window starts from zero
					if (rateLong[i] ? tick1s : tick100) begin // RULE5
						rateHold[i] <= count[i] + {31'h0, edgeSeen[i]};
						count[i] <= 32'h00000000;
					end else if (edgeSeen[i])
						count[i] <= count[i] + 32'h00000001; // RULE5
				end
				`FCPC_MODE_REPEAT: begin
					if (edgeSeen[i]) begin
						if (count[i][15:0] + 16'h0001 >= setp[i][15:0])
							count[i] <= 32'h00000000; // RULE4
						else
							count[i] <= {16'h0000, count[i][15:0] + 16'h0001}; // RULE4
					end
				end
				default: begin
					if (edgeSeen[i])
						count[i] <= countDown[i] ? count[i] - 32'h00000001 :
							count[i] + 32'h00000001; // RULE2
				end
			endcase
			if (scanStrobe)
				snap[i] <= (modeCfg[2*i +: 2] == `FCPC_MODE_RATE) ? rateHold[i] :
					count[i]; // RULE11
		end
	end
end
////////////////////////////////////////////////////////////////////////////////
// outputs
reg [NOUT-1:0] cond;
reg [2:0] chSel;
always @* begin : condComb
	integer i;
	i = 0;
	cond = {NOUT{1'b0}};
	chSel = 3'h0;
	for (i = 0; i < NOUT; i = i + 1) begin
		chSel = outCfg[i][`FCPC_OC_CH_LSB +: 3];
		// channel numbers above four never fire
		if (chSel < NCH) begin
			// equality works for both count directions
			if (outCfg[i][`FCPC_OC_TRIG_LSB +: 2] == `FCPC_TRIG_SETP)
				cond[i] = (count[chSel] == setp[chSel]); // RULE6
			else
				cond[i] = (count[chSel] == finalVal[chSel]); // RULE6
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// the first cycle after reset is masked so a condition already true
// out of reset does not fire an output
wire [NOUT-1:0] condRise = {NOUT{condValid}} & cond & ~condPrev;
wire [NOUT-1:0] condFall = {NOUT{condValid}} & ~cond & condPrev;
// a write to the status word releases latched outputs; a new hit in the
// same cycle wins over the release
wire [NOUT-1:0] outClr = (regWr && regAddr == `FCPC_REG_OUTSTAT) ? regWrData[NOUT-1:0] :
	{NOUT{1'b0}};
reg [NOUT-1:0] next_outPin;
reg [NOUT-1:0] next_dlyArmed;
// load and step are split so the delay counters have one clocked writer
reg [NOUT-1:0] dlyLoad;
reg [NOUT-1:0] dlyStep;

always @* begin : outComb
	integer i;
	i = 0;
	next_outPin = outPin;
	next_dlyArmed = dlyArmed;
	dlyLoad = {NOUT{1'b0}};
	dlyStep = {NOUT{1'b0}};
	for (i = 0; i < NOUT; i = i + 1) begin
		case (outCfg[i][`FCPC_OC_TRIG_LSB +: 2])
			`FCPC_TRIG_SETP, `FCPC_TRIG_FINAL: begin
				if (outCfg[i][`FCPC_OC_LATCH_BIT])
					next_outPin[i] = (outPin[i] & ~outClr[i]) | condRise[i]; // RULE7
				else
					next_outPin[i] = condRise[i]; // RULE8
			end
			`FCPC_TRIG_EDGE: begin
				if (outCfg[i][`FCPC_OC_FALL_BIT] ? condFall[i] : condRise[i])
					next_outPin[i] = ~outPin[i]; // RULE9
			end
			`FCPC_TRIG_DELAY: begin
				if (condRise[i]) begin
					next_dlyArmed[i] = 1'b1;
					dlyLoad[i] = 1'b1; // RULE10
				end else if (dlyArmed[i] && msTick) begin
					if (dlyCnt[i] == 14'h0000) begin
						next_dlyArmed[i] = 1'b0;
						next_outPin[i] = 1'b1; // RULE10
					end else
						dlyStep[i] = 1'b1;
				end
			end
			default: next_outPin[i] = 1'b0;
		endcase
	end
end
////////////////////////////////////////////////////////////////////////////////
// delay counts whole ms ticks, so the output may lag by up to one extra ms
always @(posedge clk_sys or negedge rst_n) begin : outRegs
	integer i;
	if (!rst_n) begin
		outPin <= {NOUT{1'b0}};
		condPrev <= {NOUT{1'b0}};
		condValid <= 1'b0;
		dlyArmed <= {NOUT{1'b0}};
		for (i = 0; i < NOUT; i = i + 1)
			dlyCnt[i] <= 14'h0000;
	end else begin
		outPin <= next_outPin;
		condPrev <= cond;
		condValid <= 1'b1;
		dlyArmed <= next_dlyArmed;
		for (i = 0; i < NOUT; i = i + 1) begin
			if (dlyLoad[i])
				dlyCnt[i] <= outCfg[i][`FCPC_OC_DLY_LSB +: 14]; // RULE10
			else if (dlyStep[i])
				dlyCnt[i] <= dlyCnt[i] - 14'h0001;
		end
	end
end
////////////////////////////////////////////////////////////////////////////////
// register writes
always @(posedge clk_sys or negedge rst_n) begin : cfgRegs
	integer i;
	if (!rst_n) begin
		modeCfg <= {2*NCH{1'b0}};
		rateLong <= {NCH{1'b0}};
		liveSel <= {NCH{1'b0}};
		for (i = 0; i < NCH; i = i + 1) begin
			setp[i] <= 32'h00000000;
			finalVal[i] <= 32'h00000000;
		end
		for (i = 0; i < NOUT; i = i + 1)
			outCfg[i] <= 32'h00000000;
	end else if (regWr) begin
		if (regAddr == `FCPC_REG_CHCFG)
			modeCfg <= regWrData[2*NCH-1:0]; // RULE1
		if (regAddr == `FCPC_REG_CTRL) begin
			rateLong <= regWrData[NCH-1:0]; // RULE5
			liveSel <= regWrData[8 +: NCH]; // RULE12
		end
		for (i = 0; i < NCH; i = i + 1) begin
			if (regAddr == `FCPC_REG_SETP0 + i[7:0])
				setp[i] <= regWrData;
			if (regAddr == `FCPC_REG_FINAL0 + i[7:0])
				finalVal[i] <= regWrData;
		end
		for (i = 0; i < NOUT; i = i + 1)
			if (regAddr == `FCPC_REG_OUTCFG0 + i[7:0])
				outCfg[i] <= regWrData;
	end
end
////////////////////////////////////////////////////////////////////////////////
// register reads, data one cycle after the strobe; unmapped reads zero
reg [31:0] rdMux;
always @* begin : rdComb
	integer i;
	i = 0;
	rdMux = 32'h00000000;
	case (regAddr)
		`FCPC_REG_CHCFG: rdMux = {{(32-2*NCH){1'b0}}, modeCfg};
		`FCPC_REG_CTRL: rdMux = {{(24-NCH){1'b0}}, liveSel, 3'h0, rateLong};
		`FCPC_REG_OUTSTAT: rdMux = {{(32-NOUT){1'b0}}, outPin};
		`FCPC_REG_DIFF0: rdMux = diff0; // RULE3
		`FCPC_REG_DIFF1: rdMux = diff1; // RULE3
		default: rdMux = 32'h00000000;
	endcase
	for (i = 0; i < NCH; i = i + 1) begin
		// live reads bypass the snapshot so a local host sees counts between scans
		if (regAddr == `FCPC_REG_COUNT0 + i[7:0])
			rdMux = liveSel[i] ? count[i] : snap[i]; // RULE12
		if (regAddr == `FCPC_REG_SETP0 + i[7:0])
			rdMux = setp[i];
		if (regAddr == `FCPC_REG_FINAL0 + i[7:0])
			rdMux = finalVal[i];
	end
	for (i = 0; i < NOUT; i = i + 1)
		if (regAddr == `FCPC_REG_OUTCFG0 + i[7:0])
			rdMux = outCfg[i];
end

always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n)
		regRdData <= 32'h00000000;
	else
		regRdData <= regRd ? rdMux : 32'h00000000;
end

endmodule

// file: tb/fcpc_counter_sva.sv
module fcpc_counter_sva (
	// clock and reset
	input wire clk_sys,
	input wire rst_n,
	// register port and outputs
	input wire [7:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWr,
	input wire regRd,
	input wire [31:0] regRdData,
	input wire [7:0] outPin
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// write then read of one place returns the written bits under mask
	property p_rdbk(a, m);
		regWr && regAddr == a ##1 regRd && regAddr == a |=>
			(regRdData & m) == ($past(regWrData, 2) & m);
	endproperty
	chk_rd_idle: assert property (!$past(regRd) |-> regRdData == 32'h0)
		else $error("read data not zero outside read");
	chk_unmap_rd: assert property (regRd && regAddr == 8'h02 |=> regRdData == 32'h0)
		else $error("unmapped read not zero");
	chk_out_reset: assert property ($rose(rst_n) |-> outPin == 8'h00)
		else $error("outputs not clear after reset");
	chk_mode_rdbk: assert property (p_rdbk(8'h00, 32'h3FF))
		else $error("mode readback");
	chk_setp_rdbk: assert property (p_rdbk(8'h20, 32'hFFFFFFFF))
		else $error("setpoint readback");
	chk_final_rdbk: assert property (p_rdbk(8'h30, 32'hFFFFFFFF))
		else $error("final readback");
	chk_ocfg_rdbk: assert property (p_rdbk(8'h40, 32'hFFF7))
		else $error("output config readback");
	chk_ctrl_rdbk: assert property (p_rdbk(8'h01, 32'h1F1F))
		else $error("control readback");
	cover property (regRd && regAddr == 8'h51);
	cover property ($rose(outPin[0]));
	cover property (regWr ##1 regRd);
endmodule

// file: tb/fcpc_host_model.sv
module fcpc_host_model #(
	parameter PERIOD = 64
) (
	// clock and reset
	input wire clk_sys,
	input wire rst_n,
	// scan
	output logic scanStrobe
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	// a scan every period without any request; short period keeps the run brief
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			scanStrobe <= 1'b0;
		end else begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			scanStrobe <= (cnt == PERIOD - 1);
		end
	end
endmodule

// file: tb/five_channel_pulse_counter_tb_top.sv
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module five_channel_pulse_counter_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 0, rst_n = 0, regWr = 0, regRd = 0;
	logic [4:0] pulseIn = 5'h00, countDown = 5'h00;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0;
	wire scanStrobe;
	wire [31:0] regRdData;
	wire [7:0] outPin;
	int n_errors = 0, comparisons = 0;
	always #12.5 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////
	fcpc_counter #(.MS_CYCLES(4)) fcpc_counter_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.pulseIn(pulseIn), .countDown(countDown), .scanStrobe(scanStrobe),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .outPin(outPin));
	fcpc_host_model fcpc_host_model_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.scanStrobe(scanStrobe));
	////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			regWr <= 1'b0;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
		@(posedge clk_sys);
		regWr <= 1'b0;
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1;
		`CHK(n, e, regRdData)
	endtask
	// pin held four cycles each level, far below the synchroniser's limit
	task automatic pulse(input int ch, input int n);
		repeat (n) begin
			@(posedge clk_sys);
			pulseIn[ch] <= 1'b1;
			repeat (4) @(posedge clk_sys);
			pulseIn[ch] <= 1'b0;
			repeat (3) @(posedge clk_sys);
		end
	endtask
	task automatic stop_test;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		stop_test();
	end
	initial begin
		cyc(3);
		rst_n <= 1'b1;
		rd(8'h10, 32'h0, "count0 reset");
		`CHK("outputs reset", 8'h00, outPin)
		wr(8'h00, 32'h025); // ch0 ch1 paired, ch2 repeat
		rd(8'h00, 32'h025, "modes");
		wr(8'h20, 32'h5);
		rd(8'h20, 32'h5, "setpoint0");
		wr(8'h22, 32'h3);
		wr(8'h30, 32'h64);
		rd(8'h30, 32'h64, "final0");
		wr(8'h40, 32'h0040);
		rd(8'h40, 32'h0040, "outcfg0");
		wr(8'h01, 32'h100);
		rd(8'h01, 32'h100, "ctrl");
		wr(8'h02, 32'hFF);
		rd(8'h02, 32'h0, "unmapped");
		cyc(1);
		pulse(0, 5);
		pulse(1, 2);
		pulse(2, 4);
		cyc(10);
		@(negedge clk_sys);
		`CHK("out0 at setpoint", 1'b1, outPin[0])
		rd(8'h10, 32'h5, "count0 live");
		cyc(70);
		rd(8'h12, 32'h1, "count2 repeat");
		rd(8'h51, 32'h3, "diff01");
		@(posedge clk_sys);
		countDown[0] <= 1'b1;
		pulse(0, 2);
		cyc(70);
		rd(8'h10, 32'h3, "count0 down");
		`CHK("out0 latched", 1'b1, outPin[0])
		wr(8'h34, 32'h2);
		wr(8'h41, 32'h24);
		wr(8'h42, 32'h234);
		cyc(1);
		pulse(4, 2);
		rd(8'h50, 32'h3, "outstat edge");
		cyc(20);
		rd(8'h50, 32'h7, "outstat delay");
		wr(8'h50, 32'h1);
		rd(8'h50, 32'h6, "latch release");
		wr(8'h00, 32'h0E5);
		cyc(1);
		fork
			pulse(3, 150);
			begin
				cyc(1000);
				rd(8'h13, 32'd50, "rate3");
			end
		join
		stop_test();
	end
endmodule
bind fcpc_counter fcpc_counter_sva fcpc_counter_sva_inst (.clk_sys(clk_sys), .rst_n(rst_n),
	.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
	.regRdData(regRdData), .outPin(outPin));
